// [include/rqff_pkg.sv]
package rqff_pkg;

	// queue geometry, word addressed
	localparam int RQFF_ADDR_W     = 11;
	localparam int RQFF_LEN_W      = 12;
	localparam int RQFF_BC_W       = 11;

	// byte offsets of a queued frame, and their word indices
	localparam int RQFF_OFF_STATUS = 0;
	localparam int RQFF_OFF_COUNT  = 2;
	localparam int RQFF_OFF_DATA   = 4;
	localparam logic [RQFF_ADDR_W-1:0] RQFF_IDX_COUNT =
		RQFF_ADDR_W'(RQFF_OFF_COUNT / 2);
	localparam logic [RQFF_ADDR_W-1:0] RQFF_IDX_DATA =
		RQFF_ADDR_W'(RQFF_OFF_DATA / 2);

	// frame size limits
	localparam logic [RQFF_BC_W-1:0]  RQFF_MAX_DATA = 11'h077C; // 1916
	localparam logic [RQFF_LEN_W-1:0] RQFF_MAX_LEN  = 12'h05EE; // 1518
	localparam logic [15:0]           RQFF_TYPE_MIN = 16'h05DC; // 1500
	localparam logic [2:0]            RQFF_CRC_BYTES = 3'h4;

	// address bytes of interest
	localparam logic [RQFF_LEN_W-1:0] RQFF_DA_LAST  = 12'h0005;
	localparam logic [RQFF_LEN_W-1:0] RQFF_TYPE_HI  = 12'h000C;
	localparam logic [RQFF_LEN_W-1:0] RQFF_TYPE_LO  = 12'h000D;
	localparam logic [7:0]            RQFF_BC_BYTE  = 8'hFF;

	// status word fields
	localparam int RQFF_B_VALID   = 15;
	localparam int RQFF_B_PORT_HI = 9;
	localparam int RQFF_B_PORT_LO = 8;
	localparam int RQFF_B_BCAST   = 7;
	localparam int RQFF_B_MCAST   = 6;
	localparam int RQFF_B_UCAST   = 5;
	localparam int RQFF_B_FTYPE   = 3;
	localparam int RQFF_B_TLONG   = 2;
	localparam int RQFF_B_RUNT    = 1;
	localparam int RQFF_B_CRCERR  = 0;
	localparam int RQFF_BC_MSB    = 10;

	localparam logic [15:0] RQFF_WORD_RST = 16'h0000;

	typedef enum logic [4:0] {
		RQFF_S_IDLE = 5'b00001,
		RQFF_S_DATA = 5'b00010,
		RQFF_S_TAIL = 5'b00100,
		RQFF_S_STAT = 5'b01000,
		RQFF_S_CNT  = 5'b10000
	} rqff_state_t;

endpackage

// [src/rqff_framer.sv]
`timescale 1ns/1ns
// Contract
// [R1] Each frame is stored as status word at 0, byte count at 2, data from 4.
// [R2] No more than 1916 data bytes are ever stored for one frame.
// [R3] With stripping on the last four bytes are dropped, else they are kept.
// [R4] The presented status always belongs to the frame at the queue head.
// [R5] The valid flag is set only for a fully received frame, clear otherwise.
// [R6] Source port goes in bits 9:8 as 01 for port 1 and 10 for port 2 only.
// [R7] The broadcast flag is set for an all-ones destination address.
// [R8] The multicast flag is set for group addresses, broadcast included.
// [R9] The unicast flag is set for an individual destination address.
// [R10] The type flag is set when the length/type field is above 1500.
// [R11] Frames above 1518 bytes get the too-long flag and are not truncated; the code drops them unless bad frames pass and caps data at 1916 bytes.
// [R12] Runt frames are flagged and queued only when bad frames pass.
// [R13] Checksum failures are flagged and queued only when bad frames pass.
// [R14] The count word holds the byte count in bits 10:0, above reserved.
// [R15] Reserved bits of both words read as zero.
// [R16] The host reads the words only after seeing valid, bounded by count.
module rqff_framer
	import rqff_pkg::*;
#(
	parameter int QUEUE_WORDS = 2048
)
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   nrst,
	// configuration
	input  wire logic                   crc_strip_en,
	input  wire logic                   pass_bad_frame,
	// receive byte stream from the mac
	input  wire logic                   rx_valid,
	input  wire logic [7:0]             rx_data,
	input  wire logic                   rx_last,
	input  wire logic                   rx_port,
	input  wire logic                   rx_crc_err,
	input  wire logic                   rx_runt,
	output      logic                   rx_ready,
	// host side of the queue
	input  wire logic                   host_rd_en,
	input  wire logic [RQFF_ADDR_W-1:0] host_rd_offset,
	input  wire logic                   host_release,
	output      logic [15:0]            host_rd_data,
	output      logic                   frame_valid_flag,
	output      logic [15:0]            receive_status_register,
	output      logic [15:0]            received_byte_count,
	output      logic                   frame_dropped
);

	logic [15:0]            receive_queue [QUEUE_WORDS];
	rqff_state_t            state;
	rqff_state_t            next_state;
	logic [RQFF_ADDR_W-1:0] frame_base;
	logic [RQFF_ADDR_W-1:0] cur_ptr;
	logic [RQFF_ADDR_W-1:0] head_ptr;
	logic [RQFF_ADDR_W:0]   frame_count;
	logic [RQFF_BC_W-1:0]   stored_cnt;
	logic [RQFF_LEN_W-1:0]  frame_len;
	logic [7:0]             dly [4];
	logic [2:0]             dly_fill;
	logic [7:0]             low_byte;
	logic                   have_low;
	logic                   strip_lat;
	logic                   port_lat;
	logic                   da_bc;
	logic                   da_mc;
	logic [7:0]             type_hi;
	logic                   ftype;
	logic                   ovf;
	logic                   err_crc;
	logic                   err_runt;

	// stream side decode
	wire accept     = rx_valid & rx_ready;
	wire first_byte = accept & (frame_len == '0);
	wire dly_full   = dly_fill == RQFF_CRC_BYTES;
	wire blocked    = (frame_count != '0) & (cur_ptr == head_ptr);
	wire in_da      = frame_len <= RQFF_DA_LAST;
	wire is_ff      = rx_data == RQFF_BC_BYTE;
	wire too_long   = frame_len > RQFF_MAX_LEN;
	wire bad_frame  = err_crc | err_runt | too_long;
	wire commit_ok  = ~ovf & (pass_bad_frame | ~bad_frame);
	wire [RQFF_LEN_W-1:0] next_len =
		(frame_len == '1) ? frame_len : frame_len + 1'b1;

	// [R3] delay line holds back the checksum
	wire [7:0] emit_byte = strip_lat ? dly[0] : rx_data;
	// [R2] data area capped
	wire room     = stored_cnt < RQFF_MAX_DATA;
	wire emit_vld = accept & (~strip_lat | dly_full) & room & ~ovf;
	wire word_wr  = emit_vld & have_low & ~blocked;
	wire tail_wr  = (state == RQFF_S_TAIL) & have_low & ~blocked &
		commit_ok;
	wire hit_full = (emit_vld & have_low & blocked) |
		((state == RQFF_S_TAIL) & have_low & blocked);

	// [R6] one-hot port code, never 00 or 11
	wire [1:0] port_code = port_lat ? 2'b10 : 2'b01;

	// [R15] status word, reserved bits zero
	logic [15:0] status_word;
	always_comb
	begin
		status_word = RQFF_WORD_RST;
		// [R5] valid bit only in committed frames
		status_word[RQFF_B_VALID] = 1'b1;
		status_word[RQFF_B_PORT_HI:RQFF_B_PORT_LO] = port_code;
		// [R7] broadcast flag
		status_word[RQFF_B_BCAST] = da_bc;
		// [R8] broadcast counts as multicast
		status_word[RQFF_B_MCAST] = da_mc;
		// [R9] unicast flag
		status_word[RQFF_B_UCAST] = ~da_mc;
		// [R10] type flag
		status_word[RQFF_B_FTYPE] = ftype;
		// [R11] length flag; counts as a bad frame, data still capped at 1916 bytes
		status_word[RQFF_B_TLONG] = too_long;
		// [R12] runt flag
		status_word[RQFF_B_RUNT] = err_runt;
		// [R13] checksum flag
		status_word[RQFF_B_CRCERR] = err_crc;
	end

	// [R14] count word, upper bits reserved
	wire [15:0] count_word = {{(15-RQFF_BC_MSB){1'b0}}, stored_cnt};

	// [R1] single write port: data, then status at 0, count at 2
	wire in_stat = state == RQFF_S_STAT;
	wire in_cnt  = state == RQFF_S_CNT;
	wire mem_we  = word_wr | tail_wr | ((in_stat | in_cnt) & commit_ok);
	wire [RQFF_ADDR_W-1:0] mem_wa = in_stat ? frame_base :
		in_cnt ? frame_base + RQFF_IDX_COUNT : cur_ptr;
	wire [15:0] mem_wd = in_stat ? status_word :
		in_cnt ? count_word :
		(state == RQFF_S_TAIL) ? {8'h00, low_byte} :
		{emit_byte, low_byte};

	always_ff @(posedge clk)
	begin
		if (mem_we)
			receive_queue[mem_wa] <= mem_wd;
	end

	// host side decode
	wire [15:0] head_stat_mem = receive_queue[head_ptr];
	wire [15:0] head_cnt_mem  = receive_queue[head_ptr + RQFF_IDX_COUNT];
	wire [RQFF_BC_W-1:0] head_bc = head_cnt_mem[RQFF_BC_MSB:0];
	wire [RQFF_BC_W-1:0] head_words = (head_bc + 1'b1) >> 1;
	wire pending = frame_count != '0;
	wire release_ok = host_release & pending;
	wire commit = in_cnt & commit_ok;
	wire [RQFF_ADDR_W-1:0] rd_addr = head_ptr + host_rd_offset;

	always_comb
	begin
		next_state = state;
		case (state)
			RQFF_S_IDLE:
				next_state = RQFF_S_DATA;
			RQFF_S_DATA:
				if (accept & rx_last)
					next_state = RQFF_S_TAIL;
			RQFF_S_TAIL:
				next_state = RQFF_S_STAT;
			RQFF_S_STAT:
				next_state = RQFF_S_CNT;
			RQFF_S_CNT:
				next_state = RQFF_S_IDLE;
			default:
				next_state = RQFF_S_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state    <= RQFF_S_IDLE;
			rx_ready <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			rx_ready <= next_state == RQFF_S_DATA;
		end
	end

	// per-frame capture; idle re-arms everything for the next frame
	always_ff @(posedge clk)
	begin
		if (!nrst || state == RQFF_S_IDLE)
		begin
			frame_len <= '0;
			stored_cnt <= '0;
			dly_fill  <= '0;
			have_low  <= 1'b0;
			low_byte  <= 8'h00;
			ovf       <= 1'b0;
			da_bc     <= 1'b0;
			da_mc     <= 1'b0;
			type_hi   <= 8'h00;
			ftype     <= 1'b0;
			err_crc   <= 1'b0;
			err_runt  <= 1'b0;
		end
		else if (accept)
		begin
			frame_len <= next_len;
			if (strip_lat & ~dly_full)
				dly_fill <= dly_fill + 1'b1;
			if (emit_vld)
			begin
				stored_cnt <= stored_cnt + 1'b1;
				have_low   <= ~have_low;
				if (~have_low)
					low_byte <= emit_byte;
			end
			if (first_byte)
			begin
				da_bc <= is_ff;
				da_mc <= rx_data[0];
			end
			else if (in_da)
				da_bc <= da_bc & is_ff;
			if (frame_len == RQFF_TYPE_HI)
				type_hi <= rx_data;
			if (frame_len == RQFF_TYPE_LO)
				ftype <= {type_hi, rx_data} > RQFF_TYPE_MIN;
			if (rx_last)
			begin
				err_crc  <= rx_crc_err;
				err_runt <= rx_runt;
			end
		end
		if (nrst && hit_full)
			ovf <= 1'b1;
	end

	// strap-like latches taken at the start of each frame
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			strip_lat <= 1'b0;
			port_lat  <= 1'b0;
		end
		else if (state == RQFF_S_IDLE)
			strip_lat <= crc_strip_en;
		else if (first_byte)
			port_lat <= rx_port;
	end

	// [R3] checksum window shifts once full
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_dly
			always_ff @(posedge clk)
			begin
				if (!nrst)
					dly[gi] <= 8'h00;
				else if (accept & strip_lat)
				begin
					if (dly_full)
						dly[gi] <= (gi == 3) ? rx_data : dly[(gi + 1) % 4];
					else if (dly_fill == 3'(gi))
						dly[gi] <= rx_data;
				end
			end
		end
	endgenerate

	// [R1] data begins two words past the frame base
	always_ff @(posedge clk)
	begin
		if (!nrst)
			cur_ptr <= RQFF_IDX_DATA;
		else if (state == RQFF_S_IDLE)
			cur_ptr <= frame_base + RQFF_IDX_DATA;
		else if (word_wr | tail_wr)
			cur_ptr <= cur_ptr + 1'b1;
	end

	// queue occupancy; a dropped frame simply leaves the base in place
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			frame_base    <= '0;
			head_ptr      <= '0;
			frame_count   <= '0;
			frame_dropped <= 1'b0;
		end
		else
		begin
			frame_dropped <= in_cnt & ~commit_ok;
			if (commit)
				frame_base <= cur_ptr;
			// [R12] bad frames are not committed unless passed; a drop pulses frame_dropped
			if (release_ok)
				head_ptr <= head_ptr + RQFF_IDX_DATA + head_words;
			frame_count <= frame_count + (commit ? 1'b1 : 1'b0) -
				(release_ok ? 1'b1 : 1'b0);
		end
	end

	// head view for the host; flag, status and count clear on a release, host_rd_data holds its last read
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			frame_valid_flag        <= 1'b0;
			receive_status_register <= RQFF_WORD_RST;
			received_byte_count     <= RQFF_WORD_RST;
			host_rd_data            <= RQFF_WORD_RST;
		end
		else
		begin
			// [R5] set only when a completed frame is queued
			frame_valid_flag <= pending & ~release_ok;
			// [R4] always the head frame, never the one arriving
			receive_status_register <= (pending & ~release_ok) ?
				head_stat_mem : RQFF_WORD_RST;
			received_byte_count <= (pending & ~release_ok) ?
				head_cnt_mem : RQFF_WORD_RST;
			// [R16] host bounds its reads by the count word
			if (host_rd_en)
				host_rd_data <= receive_queue[rd_addr];
		end
	end

endmodule

// [bench/rqff_framer_sva.sv]
`timescale 1ns/1ns
module rqff_framer_sva
	import rqff_pkg::*;
(
	// clock and reset
	input wire logic			clk,
	input wire logic			nrst,
	// receive stream
	input wire logic			rx_valid,
	input wire logic			rx_last,
	input wire logic			rx_ready,
	// host side
	input wire logic			host_rd_en,
	input wire logic [RQFF_ADDR_W-1:0]	host_rd_offset,
	input wire logic			host_release,
	input wire logic [15:0]		host_rd_data,
	input wire logic			frame_valid_flag,
	input wire logic [15:0]		receive_status_register,
	input wire logic [15:0]		received_byte_count,
	input wire logic			frame_dropped
);
	wire [15:0]	st = receive_status_register;
	wire [15:0]	bc = received_byte_count;
	wire		fv = frame_valid_flag;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_end;
		rx_valid && rx_ready && rx_last;
	endsequence
	sequence s_gap;
		!rx_ready [*4] ##1 rx_ready;
	endsequence
	sequence s_free;
		host_release && fv;
	endsequence
	ready_gap_a: assert property (s_end |=> s_gap)
		else $error("ready gap wrong");
	empty_zero_a: assert property (
		!fv |-> st == 16'h0000 && bc == 16'h0000)
		else $error("words not zero while empty");
	valid_bit_a: assert property (fv |-> st[RQFF_B_VALID])
		else $error("valid bit missing");
	port_code_a: assert property (
		fv |-> st[9:8] inside {2'b01, 2'b10})
		else $error("bad port code");
	addr_class_a: assert property (
		fv |-> st[5] != st[6] && (!st[7] || st[6]))
		else $error("address class bits wrong");
	reserved_zero_a: assert property (
		st[14:10] == 5'h00 && !st[4] && bc[15:11] == 5'h00)
		else $error("reserved bits set");
	count_cap_a: assert property (bc[10:0] <= RQFF_MAX_DATA)
		else $error("count above cap");
	read_status_a: assert property (
		host_rd_en && host_rd_offset == 11'h000 && fv
		|=> host_rd_data == $past(st))
		else $error("status read wrong");
	read_count_a: assert property (
		host_rd_en && host_rd_offset == RQFF_IDX_COUNT && fv
		|=> host_rd_data == $past(bc))
		else $error("count read wrong");
	release_a: assert property (s_free |=> !fv)
		else $error("release ignored");
	drop_pulse_a: assert property (frame_dropped |=> !frame_dropped)
		else $error("drop pulse too long");
endmodule
bind rqff_framer rqff_framer_sva i_rqff_framer_sva (.clk(clk), .nrst(nrst),
	.rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready),
	.host_rd_en(host_rd_en), .host_rd_offset(host_rd_offset),
	.host_release(host_release), .host_rd_data(host_rd_data),
	.frame_valid_flag(frame_valid_flag), .frame_dropped(frame_dropped),
	.receive_status_register(receive_status_register),
	.received_byte_count(received_byte_count));

// [bench/rqff_host_model.sv]
`timescale 1ns/1ns
module rqff_host_model
	import rqff_pkg::*;
(
	// clock and reset
	input wire logic			clk,
	input wire logic			nrst,
	// queue side
	input wire logic			frame_valid_flag,
	input wire logic [15:0]		host_rd_data,
	output logic			host_rd_en,
	output logic [RQFF_ADDR_W-1:0]	host_rd_offset,
	output logic			host_release,
	// pacing and results
	input wire logic [3:0]		slow,
	output int				nrx
);
	logic [15:0]	sq[$];
	logic [15:0]	cq[$];
	logic [15:0]	dat[1024];
	int		n;
	initial
	begin
		host_rd_en = 1'b0;
		host_rd_offset = 11'h000;
		host_release = 1'b0;
		nrx = 0;
		forever
		begin
			@(negedge clk);
			if (nrst && frame_valid_flag)
			begin
				repeat (slow) @(negedge clk);
				host_rd_en = 1'b1;
				host_rd_offset = 11'h000;
				@(negedge clk);
				sq.push_back(host_rd_data);
				host_rd_offset = RQFF_IDX_COUNT;
				@(negedge clk);
				cq.push_back(host_rd_data);
				n = (int'(host_rd_data[10:0]) + 1) / 2;
				for (int i = 0; i < n; i++)
				begin
					host_rd_offset = RQFF_IDX_DATA + 11'(i);
					@(negedge clk);
					dat[i] = host_rd_data;
				end
				host_rd_en = 1'b0;
				// idle offset must not look meaningful
				host_rd_offset = ~host_rd_offset;
				host_release = 1'b1;
				@(negedge clk);
				host_release = 1'b0;
				nrx = nrx + 1;
				@(negedge clk);
			end
		end
	end
endmodule

// [bench/tb.sv]
`timescale 1ns/1ns
module tb
	import rqff_pkg::*;
;
	logic		clk, nrst, crc_strip_en, pass_bad_frame, rx_valid, rx_last;
	logic		rx_port, rx_crc_err, rx_runt, rx_ready, host_rd_en;
	logic		host_release, frame_valid_flag, frame_dropped;
	logic [7:0]	rx_data;
	logic [10:0]	host_rd_offset;
	logic [15:0]	host_rd_data, receive_status_register, received_byte_count, e;
	logic [3:0]	slow;
	logic [7:0]	fb[2100];
	int		nrx, k, bad_count = 0, compares = 0, ndrop = 0;
	bit		strip_q = 1'b0, strip_use;
	rqff_framer i_rqff_framer (.clk, .nrst, .crc_strip_en, .pass_bad_frame,
		.rx_valid, .rx_data, .rx_last, .rx_port, .rx_crc_err, .rx_runt,
		.rx_ready, .host_rd_en, .host_rd_offset, .host_release, .host_rd_data,
		.frame_valid_flag, .receive_status_register, .received_byte_count,
		.frame_dropped);
	rqff_host_model i_rqff_host_model (.clk, .nrst, .frame_valid_flag,
		.host_rd_data, .host_rd_en, .host_rd_offset, .host_release, .slow, .nrx);
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(negedge clk) if (frame_dropped === 1'b1) ndrop++;
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// negative k waits for ready, else for k frames read
	task automatic waitc(int k);
		int t;
		t = 0;
		while ((k < 0 ? rx_ready !== 1'b1 : nrx < k) && t < 20000)
		begin
			@(negedge clk);
			t++;
		end
		if (t == 20000)
		begin
			bad_count++;
			close_out;
		end
	endtask
	function automatic logic [15:0] exp_stat(bit p, int n, bit ce, bit ru);
		logic [15:0] s;
		s = 16'h8000;
		s[9:8] = p ? 2'b10 : 2'b01;
		s[7] = {fb[0], fb[1], fb[2], fb[3], fb[4], fb[5]} == 48'hFFFF_FFFF_FFFF;
		s[6] = fb[0][0];
		s[5] = !fb[0][0];
		s[3] = n >= 14 && {fb[12], fb[13]} > RQFF_TYPE_MIN;
		s[2] = n > RQFF_MAX_LEN;
		s[1] = ru;
		s[0] = ce;
		return s;
	endfunction
	// kind 0 unicast, 1 multicast, 2 broadcast
	task automatic send(bit p, int n, int kind, logic [15:0] ty, bit ce, bit ru);
		strip_use = strip_q;
		for (int i = 0; i < n; i++)
			fb[i] = 8'($urandom);
		fb[0][0] = kind != 0;
		fb[1] = kind == 1 ? 8'h00 : fb[1];
		for (int i = 0; i < 6; i++)
			fb[i] = kind == 2 ? 8'hFF : fb[i];
		{fb[12], fb[13]} = ty;
		for (int i = 0; i < n; i++)
		begin
			waitc(-1);
			rx_valid = 1'b1;
			rx_data = fb[i];
			rx_last = i == n - 1;
			rx_port = p;
			rx_crc_err = ce && i == n - 1;
			rx_runt = ru && i == n - 1;
			@(negedge clk);
		end
		rx_valid = 1'b0;
		rx_last = 1'b0;
		rx_data = ~rx_data;
		// idle after this frame latches the strip mode of the next one
		strip_q = crc_strip_en;
	endtask
	task automatic one(bit p, int n, int kind, logic [15:0] ty, bit ce, bit ru);
		int k, d, m;
		k = nrx;
		d = ndrop;
		send(p, n, kind, ty, ce, ru);
		m = n - (strip_use ? 4 : 0);
		m = m > RQFF_MAX_DATA ? RQFF_MAX_DATA : m;
		if ((ce || ru || n > RQFF_MAX_LEN) && !pass_bad_frame)
		begin
			repeat (8) @(negedge clk);
			chk("dropped", 16'(ndrop - d), 16'h0001);
			chk("queued", 16'(nrx - k), 16'h0000);
		end
		else
		begin
			waitc(k + 1);
			chk("status", i_rqff_host_model.sq.pop_front(),
				exp_stat(p, n, ce, ru));
			chk("count", i_rqff_host_model.cq.pop_front(), 16'(m));
			for (int i = 0; i < (m + 1) / 2; i++)
				chk("data", i_rqff_host_model.dat[i],
					{2 * i + 1 < m ? fb[2 * i + 1] : 8'h00, fb[2 * i]});
		end
		$display("frame done len %0d", n);
	endtask
	initial
	begin
		{crc_strip_en, pass_bad_frame, rx_valid, rx_last, rx_port} = 5'h00;
		{rx_crc_err, rx_runt, rx_data, slow, nrst} = 15'h0000;
		void'($urandom(85934));
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		for (int c = 0; c < 6; c++)
			one(c[0], 60 + c, c % 3, c < 3 ? 16'h05DC : 16'h05DD, 0, 0);
		one(0, 1519, 0, 16'h0800, 0, 0);
		one(1, 64, 1, 16'h0800, 1, 0);
		one(0, 64, 2, 16'h0800, 0, 1);
		pass_bad_frame = 1'b1;
		// strip mode is taken in the idle cycle ahead of a frame
		crc_strip_en = 1'b1;
		one(1, 2000, 0, 16'h0800, 1, 1);
		crc_strip_en = 1'b0;
		one(0, 67, 1, 16'h0800, 0, 1);
		slow = 4'hF;
		k = nrx;
		send(0, 64, 0, 16'h0800, 0, 0);
		e = exp_stat(0, 64, 0, 0);
		send(1, 70, 2, 16'h0040, 0, 0);
		waitc(k + 2);
		chk("head status", i_rqff_host_model.sq.pop_front(), e);
		chk("next status", i_rqff_host_model.sq.pop_front(),
			exp_stat(1, 70, 0, 0));
		chk("head count", i_rqff_host_model.cq.pop_front(), 16'h0040);
		chk("next count", i_rqff_host_model.cq.pop_front(), 16'h0046);
		$display("back to back done");
		for (int r = 0; r < 20; r++)
		begin
			crc_strip_en = 1'($urandom);
			pass_bad_frame = 1'($urandom);
			slow = 4'($urandom);
			one(1'($urandom), 14 + $urandom % 1600, $urandom % 3, 16'($urandom),
				$urandom % 4 == 0, $urandom % 5 == 0);
		end
		close_out;
	end
endmodule
